/* core/hsoc_phase.sv */
// Phase shifter: 32-step sampling phase counter, one step per 1/32 of a cycle.
// Assumes the line_start input marks each reference period in ref_clk cycles.
`timescale 1ns/100ps
module hsoc_phase (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [4:0] phase,
  input wire logic line_start,
  output logic aligned
);
  logic [4:0] step_q;
  logic [4:0] step_d;

  // Free step counter, restarted on every accepted sync edge
  always_comb begin
    step_d = step_q + 5'h01;
    if (line_start) begin
      step_d = 5'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      step_q <= 5'h00;
    end else begin
      step_q <= step_d;
    end
  end

  // Selected phase point; each count is 11.25 degrees of the line reference
  // Compared on the next count so a restart never matches the stale count
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aligned <= 1'b0;
    end else begin
      aligned <= (step_d == phase);
    end
  end
endmodule : hsoc_phase

/* core/hsoc_pkg.sv */
// Package for the line sync output and coast block: offsets, fields, reset values.
// Assumes a single 100 MHz pixel clock domain and an 8-bit register port.
package hsoc_pkg;
  // Register offsets (8-bit address space)
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_WIDTH = 8'h07;
  localparam logic [7:0] ADDR_POL = 8'h10;
  localparam logic [7:0] ADDR_COAST = 8'h11;
  localparam logic [7:0] ADDR_STATUS = 8'h12;
  // Field positions
  localparam int PHASE_LSB = 3;
  localparam int POL_OUT_BIT = 5;
  localparam int POL_IN_BIT = 6;
  localparam int POL_AUTO_BIT = 7;
  localparam int COAST_EN_LSB = 1;
  // Reset values
  localparam logic [4:0] PHASE_RST = 5'h00;
  localparam logic [7:0] WIDTH_RST = 8'h20;
  localparam logic [7:0] POL_RST = 8'h80;
  localparam logic [7:0] COAST_RST = 8'h00;
  // Phase steps per full cycle, and step size in hundredths of a degree
  localparam int PHASE_STEPS = 32;
  localparam int DEG_FULL_CENTI = 36000;
  localparam int STEP_CENTI = DEG_FULL_CENTI / PHASE_STEPS;
  // Sync polarity settling: samples of one level that decide the input polarity
  localparam logic [7:0] POL_VOTE_CNT = 8'h40;

  typedef struct packed {
    logic [4:0] phase;
    logic [7:0] width;
    logic out_high;
    logic in_high;
    logic auto_pol;
    logic [2:0] coast_en;
  } hsoc_cfg_t;

  typedef struct packed {
    logic sync_out;
    logic pix_clk;
    logic coast;
    logic ref_gate;
  } hsoc_out_t;
endpackage : hsoc_pkg

/* core/hsoc_top.sv */
// Line sync regeneration, polarity detect, sampling phase and coast gating.
// Assumes raw sync and coast request arrive asynchronously on pins.
//
// Overview of operation
// - Output clock runs at half rate and rises on the same edge that moves the pixel data.
// - Sampling clock reference is derived from incoming line sync.
// - Sampling phase moves through a full cycle in 32 programmable steps.
// - Input sync polarity is detected so the leading edge is found for either input polarity.
// - Output sync polarity chosen by bit 5 of register 10H.
// - Output sync is aligned with output clock and pixel data.
// - Output sync width in pixel clocks comes from register 07H.
// - Internal coast gating blocks the reference; the clock free-runs.
// - Each phase step is one thirty-second of a cycle, 11.25 degrees.
`timescale 1ns/100ps
module hsoc_top (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sync_in,
  input wire logic coast_req,
  input wire logic [23:0] pix_in,
  output logic [23:0] pix_out,
  output logic pixel_output_clock,
  output logic line_sync_output,
  output logic ref_gate,
  output logic coast_active
);
  hsoc_pkg::hsoc_cfg_t cfg_q;
  logic [1:0] sync_meta_q;
  logic [1:0] coast_meta_q;
  logic sync_prev_q;
  logic [7:0] vote_q;
  logic det_high_q;
  logic pulse_pend_q;
  logic [7:0] width_cnt_q;
  logic sync_act_q;
  logic clk_ph_q;
  logic aligned;
  logic in_high;
  logic sync_norm;
  logic lead_edge;

  // Register writes; coast enable bits steer the gating
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_q.phase <= hsoc_pkg::PHASE_RST;
      cfg_q.width <= hsoc_pkg::WIDTH_RST;
      cfg_q.out_high <= hsoc_pkg::POL_RST[hsoc_pkg::POL_OUT_BIT];
      cfg_q.in_high <= hsoc_pkg::POL_RST[hsoc_pkg::POL_IN_BIT];
      cfg_q.auto_pol <= hsoc_pkg::POL_RST[hsoc_pkg::POL_AUTO_BIT];
      cfg_q.coast_en <= hsoc_pkg::COAST_RST[hsoc_pkg::COAST_EN_LSB +: 3];
    end else if (reg_wr) begin
      case (reg_addr)
        hsoc_pkg::ADDR_PHASE: begin
          cfg_q.phase <= reg_wdata[hsoc_pkg::PHASE_LSB +: 5];
        end
        hsoc_pkg::ADDR_WIDTH: begin
          cfg_q.width <= reg_wdata;
        end
        hsoc_pkg::ADDR_POL: begin
          cfg_q.out_high <= reg_wdata[hsoc_pkg::POL_OUT_BIT];
          cfg_q.in_high <= reg_wdata[hsoc_pkg::POL_IN_BIT];
          cfg_q.auto_pol <= reg_wdata[hsoc_pkg::POL_AUTO_BIT];
        end
        hsoc_pkg::ADDR_COAST: begin
          cfg_q.coast_en <= reg_wdata[hsoc_pkg::COAST_EN_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // Read port, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        hsoc_pkg::ADDR_PHASE: reg_rdata <= {cfg_q.phase, 3'h0};
        hsoc_pkg::ADDR_WIDTH: reg_rdata <= cfg_q.width;
        hsoc_pkg::ADDR_POL: begin
          reg_rdata <= {cfg_q.auto_pol, cfg_q.in_high, cfg_q.out_high, 5'h00};
        end
        hsoc_pkg::ADDR_COAST: reg_rdata <= {4'h0, cfg_q.coast_en, 1'b0};
        hsoc_pkg::ADDR_STATUS: begin
          reg_rdata <= {5'h00, coast_active, det_high_q, line_sync_output};
        end
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync_meta_q <= 2'h0;
      coast_meta_q <= 2'h0;
    end else begin
      sync_meta_q <= {sync_meta_q[0], sync_in};
      coast_meta_q <= {coast_meta_q[0], coast_req};
    end
  end

  // Polarity vote: sync is short, so the level held most of the time is idle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      vote_q <= 8'h00;
      det_high_q <= 1'b1;
    end else if (sync_meta_q[1] == det_high_q) begin
      vote_q <= vote_q + 8'h01;
      if (vote_q == hsoc_pkg::POL_VOTE_CNT) begin
        det_high_q <= ~det_high_q;
        vote_q <= 8'h00;
      end
    end else begin
      vote_q <= 8'h00;
    end
  end

  assign in_high = cfg_q.auto_pol ? det_high_q : cfg_q.in_high;
  assign sync_norm = in_high ? sync_meta_q[1] : ~sync_meta_q[1];

  // Coast: any set enable bit lets the one coast request engage free-run gating
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      coast_active <= 1'b0;
    end else begin
      coast_active <= (|cfg_q.coast_en) & coast_meta_q[1];
    end
  end

  // Leading edge only counts while not coasting
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_norm;
    end
  end
  assign lead_edge = sync_norm & ~sync_prev_q & ~coast_active;

  // Reference to the PLL, blocked while coasting
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ref_gate <= 1'b0;
    end else begin
      ref_gate <= lead_edge;
    end
  end

  hsoc_phase u_phase (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .phase(cfg_q.phase),
    .line_start(lead_edge),
    .aligned(aligned)
  );

  // Pulse waits for the aligned phase point, then lasts width clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pulse_pend_q <= 1'b0;
      width_cnt_q <= 8'h00;
      sync_act_q <= 1'b0;
    end else begin
      if (lead_edge) begin
        pulse_pend_q <= 1'b1;
      end
      if (pulse_pend_q && aligned && !lead_edge) begin
        pulse_pend_q <= 1'b0;
        sync_act_q <= (cfg_q.width != 8'h00);
        width_cnt_q <= cfg_q.width;
      end else if (sync_act_q) begin
        width_cnt_q <= width_cnt_q - 8'h01;
        if (width_cnt_q == 8'h01) begin
          sync_act_q <= 1'b0;
        end
      end
    end
  end

  // Output stage: sync and data launched on the same edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      line_sync_output <= 1'b0;
      pix_out <= 24'h000000;
    end else begin
      line_sync_output <= cfg_q.out_high ? sync_act_q : ~sync_act_q;
      pix_out <= pix_in;
    end
  end

  // Output clock toggles on every edge, so its rise lands on the edge that moves the data
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clk_ph_q <= 1'b0;
      pixel_output_clock <= 1'b0;
    end else begin
      clk_ph_q <= ~clk_ph_q;
      pixel_output_clock <= clk_ph_q;
    end
  end
endmodule : hsoc_top

/* tb/hsoc_sink.sv */
// Display side model: latches pixels, counts lines from the regenerated sync.
// Assumes the bench configures the output sync active low.
`timescale 1ns/100ps
module hsoc_sink (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pixel_output_clock,
  input wire logic line_sync_output,
  input wire logic [23:0] pix_out,
  output logic [23:0] px_q,
  output logic [7:0] lines_q
);
  logic ck_q;
  logic ls_q;
  // Raw sync is never used here: line timing comes from the output sync only
  always_ff @(posedge ref_clk) begin
    ck_q <= pixel_output_clock;
    ls_q <= line_sync_output;
    if (pixel_output_clock && !ck_q) px_q <= pix_out;
    if (!rst_b) lines_q <= 8'h00;
    else if (ls_q && !line_sync_output) lines_q <= lines_q + 8'h01;
  end
endmodule : hsoc_sink

/* tb/hsoc_sva.sv */
// Checker for hsoc_top, bound from the bench top file.
// Assumes one ref_clk domain with synchronous active-low rst_b.
`timescale 1ns/100ps
module hsoc_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic coast_req,
  input wire logic [23:0] pix_in,
  input wire logic [23:0] pix_out,
  input wire logic pixel_output_clock,
  input wire logic line_sync_output,
  input wire logic ref_gate,
  input wire logic coast_active
);
  logic [7:0] wid_q;
  logic pol_q;
  logic [8:0] cnt_q;
  logic act;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Active level of the output sync
  assign act = line_sync_output == pol_q;
  // Shadow of width and output polarity
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wid_q <= hsoc_pkg::WIDTH_RST;
      pol_q <= 1'b0;
    end else if (reg_wr && reg_addr == hsoc_pkg::ADDR_WIDTH) begin
      wid_q <= reg_wdata;
    end else if (reg_wr && reg_addr == hsoc_pkg::ADDR_POL) begin
      pol_q <= reg_wdata[hsoc_pkg::POL_OUT_BIT];
    end
  end
  // Active cycles of the current pulse
  always_ff @(posedge ref_clk) begin
    cnt_q <= (!rst_b || !act) ? 9'h000 : cnt_q + 9'h001;
  end
  // Polarity guard skips the level flip right after a polarity write
  pix_delay_a: assert property ($past(rst_b) |-> pix_out == $past(pix_in))
    else $error("pixel data not delayed by one cycle");
  clk_toggle_a: assert property ($past(rst_b) && $past(rst_b, 2) |-> $changed(pixel_output_clock))
    else $error("output clock did not toggle");
  gate_single_a: assert property (ref_gate |=> !ref_gate)
    else $error("reference pulse longer than one cycle");
  coast_block_a: assert property ($past(coast_active) && $past(coast_active, 2) |-> !ref_gate)
    else $error("reference pulse while coasting");
  coast_cause_a: assert property (coast_active |-> $past(coast_req, 3))
    else $error("coast without request");
  pulse_width_a: assert property ($fell(act) && $past(pol_q, 5) == pol_q && $past(rst_b, 5)
    |-> cnt_q == {1'b0, wid_q})
    else $error("sync pulse width wrong");
  zero_width_a: assert property ($rose(act) && $past(pol_q, 5) == pol_q && $past(rst_b, 5)
    |-> wid_q != 8'h00)
    else $error("sync pulse with zero width");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
endmodule : hsoc_sva

/* tb/hsoc_top_tb.sv */
// Bench for hsoc_top: registers, pulse timing, coast gating, polarity.
// Assumes hsoc_sva and hsoc_sink are compiled before this file.
`timescale 1ns/100ps
`define CHK(n, e, v) begin n_compared++; if ((v) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, v); end end
module hsoc_top_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sync_in = 1'b0;
  logic coast_req = 1'b0;
  logic [23:0] pix_in = 24'h000000;
  logic [23:0] pix_out;
  logic pixel_output_clock;
  logic line_sync_output;
  logic ref_gate;
  logic coast_active;
  logic [7:0] lines;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int d0;
  int d1;
  int g;
  hsoc_top dut_u (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sync_in, .coast_req, .pix_in, .pix_out, .pixel_output_clock, .line_sync_output,
    .ref_gate, .coast_active);
  hsoc_sink sink_u (.ref_clk, .rst_b, .pixel_output_clock, .line_sync_output, .pix_out,
    .px_q(), .lines_q(lines));
  // Clock and moving pixel stream
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pix_in <= pix_in + 24'h000001;
  // Hang guard, far above the fewer than one thousand cycles used
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  // One sync pulse; d is delay to output pulse, width compared here
  task automatic t_line(input logic [4:0] ph, input logic [7:0] w, input logic iv,
      output int d);
    int n;
    wr(hsoc_pkg::ADDR_PHASE, {ph, 3'h0});
    wr(hsoc_pkg::ADDR_WIDTH, w);
    repeat (40) @(posedge ref_clk);
    sync_in <= ~iv;
    repeat (3) @(posedge ref_clk);
    sync_in <= iv;
    #1;
    for (d = 3; d < 90 && line_sync_output !== 1'b0; d++) @(posedge ref_clk) #1;
    for (n = 0; n < 300 && line_sync_output === 1'b0; n++) @(posedge ref_clk) #1;
    `CHK("width", int'(w), n)
  endtask : t_line
  task automatic t_gate(output int k);
    k = 0;
    sync_in <= 1'b1;
    // Window opens at once: the reference pulse comes three edges after the rise
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (i == 2) sync_in <= 1'b0;
      #1 if (ref_gate === 1'b1) k++;
    end
  endtask : t_gate
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(hsoc_pkg::ADDR_PHASE, {hsoc_pkg::PHASE_RST, 3'h0});
    rd(hsoc_pkg::ADDR_WIDTH, hsoc_pkg::WIDTH_RST);
    rd(hsoc_pkg::ADDR_POL, hsoc_pkg::POL_RST);
    rd(hsoc_pkg::ADDR_COAST, hsoc_pkg::COAST_RST);
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'h00);
    `CHK("idle", 1'b1, line_sync_output)
    t_line(5'h00, 8'h01, 1'b0, d0);
    t_line(5'h1f, 8'hff, 1'b0, d1);
    `CHK("phase", 31, d1 - d0)
    rd(hsoc_pkg::ADDR_PHASE, 8'hf8);
    t_line(5'h00, 8'h00, 1'b0, d0);
    `CHK("lines", 8'h02, lines)
    wr(hsoc_pkg::ADDR_POL, 8'ha0);
    repeat (4) @(posedge ref_clk);
    #1 `CHK("idle", 1'b0, line_sync_output)
    wr(hsoc_pkg::ADDR_POL, 8'h80);
    wr(hsoc_pkg::ADDR_COAST, 8'h02);
    coast_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_gate(g);
    `CHK("coast", 1'b1, coast_active)
    `CHK("gated", 0, g)
    @(posedge ref_clk);
    coast_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_gate(g);
    `CHK("gate", 1, g)
    wr(hsoc_pkg::ADDR_COAST, 8'h00);
    coast_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 `CHK("coast", 1'b0, coast_active)
    @(posedge ref_clk);
    coast_req <= 1'b0;
    sync_in <= 1'b1;
    repeat (80) @(posedge ref_clk);
    rd(hsoc_pkg::ADDR_STATUS, 8'h01);
    t_line(5'h00, 8'h04, 1'b1, d0);
    // Manual polarity set to the real (active low) input must time lines alike
    wr(hsoc_pkg::ADDR_POL, 8'h00);
    t_line(5'h00, 8'h03, 1'b1, d1);
    `CHK("manual", d0, d1)
    stop_test();
  end
endmodule : hsoc_top_tb
bind hsoc_top hsoc_sva chk_u (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .coast_req, .pix_in, .pix_out, .pixel_output_clock, .line_sync_output,
  .ref_gate, .coast_active);
